// *** host_register_window_decode.sv ***
// What this block does
// - Register offset plus side dependent base.
// - Host decodes system registers at D_0000H.
// - Processor and DMA decode at 4001_0000H.
// - Mode 00 disables host interface entirely.
// - Mode 01 refuses mirror window accesses.
// - Mode 10 sends mirror to instruction RAM.
// - Mode 11 mirrors instruction RAM, debug only.
`timescale 1ns/1ps
module host_register_window_decode
   import host_window_pkg::*;
(
   input wire logic i_clk,                                         // 100 MHz clock.
   input wire logic i_rst_n,                                       // Sync reset, low.
   input wire logic i_boot_select_high,                            // Boot strap pin, high.
   input wire logic i_boot_select_low,                             // Boot strap pin, low.
   input wire logic i_host_req,                                    // Host access strobe.
   input wire logic [host_window_pkg::HOST_ADDR_W-1:0] i_host_addr, // Host address.
   input wire logic i_cpu_req,                                     // Internal access strobe.
   input wire logic [host_window_pkg::CPU_ADDR_W-1:0] i_cpu_addr,  // Internal address.
   output logic o_host_sysreg_sel,                                 // Host hit sysreg, pulse.
   output logic o_host_iram_sel,                                   // Host hit mirror, pulse.
   output logic o_host_reject,                                     // Host refused, pulse.
   output logic [host_window_pkg::OFFSET_W-1:0] o_host_offset,     // Host register offset.
   output logic [host_window_pkg::CPU_ADDR_W-1:0] o_iram_addr,     // Mirror target address.
   output logic o_cpu_sysreg_sel,                                  // Internal hit, pulse.
   output logic o_cpu_miss,                                        // Internal miss, pulse.
   output logic [host_window_pkg::OFFSET_W-1:0] o_cpu_offset,      // Internal offset.
   output logic [1:0] o_boot_mode,                                 // Captured boot mode.
   output logic o_mode_valid,                                      // Straps captured.
   output logic o_host_if_en,                                      // Host interface on.
   output logic o_debug_boot                                       // Debug only mode.
);

   // Window test on the host address: base inclusive, base plus span exclusive.
   function automatic logic in_window(input logic [HOST_ADDR_W-1:0] addr,
                                      input logic [HOST_ADDR_W-1:0] base,
                                      input logic [HOST_ADDR_W-1:0] span);
      logic [HOST_ADDR_W-1:0] rel;
      rel = addr - base;
      return (addr >= base) && (rel < span);
   endfunction

   // Strap path.
   logic [1:0] strap_level;      // Filtered strap levels.
   logic strap_stable;           // Strap stages agree.
   strap_state_e state_r;        // Capture state.
   strap_state_e state_nxt;      // Next capture state.
   logic [1:0] settle_r;         // Settle counter after reset release.
   logic [1:0] settle_nxt;       // Next settle count.
   logic [1:0] mode_r;           // Captured boot mode.
   logic mode_valid_r;           // Mode has been captured.
   logic host_en_r;              // Host interface enabled.
   logic debug_r;                // Debug only boot mode.

   // Host decode.
   logic host_sys_hit;           // Host address in system register area.
   logic host_mir_hit;           // Host address in mirror window.
   logic mirror_to_iram;         // Current mode routes mirror to RAM.
   logic host_sys_ok;            // Host register access is served.
   logic host_mir_ok;            // Host mirror access is served.
   logic [HOST_ADDR_W-1:0] host_sys_rel;  // Host address minus register base.
   logic [HOST_ADDR_W-1:0] host_mir_rel;  // Host address minus mirror base.
   logic [CPU_ADDR_W-1:0] iram_target;    // Internal RAM address of the access.
   logic host_sysreg_r;          // Registered host register select.
   logic host_iram_r;            // Registered host mirror select.
   logic host_reject_r;          // Registered host refusal.
   logic [OFFSET_W-1:0] host_offset_r;    // Registered host offset.
   logic [CPU_ADDR_W-1:0] iram_addr_r;    // Registered mirror target.

   // Internal decode.
   logic cpu_sys_hit;            // Internal address in system register area.
   logic [CPU_ADDR_W-1:0] cpu_rel; // Internal address minus register base.
   logic cpu_sysreg_r;           // Registered internal select.
   logic cpu_miss_r;             // Registered internal miss.
   logic [OFFSET_W-1:0] cpu_offset_r; // Registered internal offset.

   // The strap pins come from outside the clock domain and are filtered.
   pin_sync #(
      .WIDTH(2)
   ) u_strap_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin({i_boot_select_high, i_boot_select_low}),
      .o_level(strap_level),
      .o_stable(strap_stable)
   );

   // The capture waits out the synchroniser depth, then takes the first stable
   // strap value and does not look at the pins again until the next reset or an illegal state code.
   always_comb
   begin
      state_nxt = state_r;
      settle_nxt = settle_r;
      unique case (state_r)
         ST_SETTLE:
         begin
            // Count the cycles needed to flush the reset value from the chain.
            settle_nxt = settle_r + 2'h1;
            if (settle_r == STRAP_SETTLE)
               state_nxt = ST_CAPTURE;
         end
         ST_CAPTURE:
         begin
            // Capture only once the stages agree, so a moving pin is not taken.
            if (strap_stable)
               state_nxt = ST_RUN;
         end
         ST_RUN:
         begin
            // The mapping is frozen here.
            state_nxt = ST_RUN;
         end
         default:
         begin
            // An illegal code restarts the capture.
            state_nxt = ST_SETTLE;
         end
      endcase
   end

   // State register and settle counter.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_r <= ST_SETTLE;
         settle_r <= 2'h0;
      end
      else
      begin
         state_r <= state_nxt;
         settle_r <= settle_nxt;
      end
   end

   // Boot mode and the controls that follow from it, loaded only in the capture state.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         mode_r <= BOOT_MODE_RST;
         mode_valid_r <= 1'b0;
         host_en_r <= 1'b0;
         debug_r <= 1'b0;
      end
      else if ((state_r == ST_CAPTURE) && strap_stable)
      begin
         mode_r <= strap_level;
         mode_valid_r <= 1'b1;
         host_en_r <= (strap_level != BOOT_EXT_MEM);
         debug_r <= (strap_level == BOOT_IRAM);
      end
   end

   // Mirror routing by mode: only the host and debug modes reach the RAM.
   assign mirror_to_iram = (mode_r == BOOT_HOST) || (mode_r == BOOT_IRAM);

   // Host side window tests against the host base of the register area and the mirror base.
   assign host_sys_hit = in_window(i_host_addr, HOST_SYSREG_BASE, SYSREG_SPAN);
   assign host_mir_hit = in_window(i_host_addr, MIRROR_BASE, MIRROR_SPAN);
   assign host_sys_rel = i_host_addr - HOST_SYSREG_BASE;
   assign host_mir_rel = i_host_addr - MIRROR_BASE;
   assign iram_target = IRAM_BASE + {{(CPU_ADDR_W-HOST_ADDR_W){1'b0}}, host_mir_rel};

   // A disabled interface serves nothing; a reserved mirror is refused.
   assign host_sys_ok = host_en_r && mode_valid_r && host_sys_hit;
   assign host_mir_ok = host_en_r && mode_valid_r && host_mir_hit && mirror_to_iram;

   // Internal side: the upper address bits must name the internal base.
   assign cpu_sys_hit = (i_cpu_addr[CPU_ADDR_W-1:OFFSET_W] ==
                         CPU_SYSREG_BASE[CPU_ADDR_W-1:OFFSET_W]);
   assign cpu_rel = i_cpu_addr - CPU_SYSREG_BASE;

   // Host answer, one cycle after the strobe; the selects are one-hot.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         host_sysreg_r <= 1'b0;
         host_iram_r <= 1'b0;
         host_reject_r <= 1'b0;
      end
      else
      begin
         host_sysreg_r <= i_host_req && host_sys_ok;
         host_iram_r <= i_host_req && host_mir_ok;
         host_reject_r <= i_host_req && !host_sys_ok && !host_mir_ok;
      end
   end

   // Host offset and mirror address, captured with each strobe; a refused one loads zero.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         host_offset_r <= '0;
         iram_addr_r <= '0;
      end
      else if (i_host_req)
      begin
         host_offset_r <= host_sys_ok ? host_sys_rel[OFFSET_W-1:0] : '0;
         iram_addr_r <= host_mir_ok ? iram_target : '0;
      end
   end

   // Internal answer, one cycle after the strobe, independent of boot mode.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         cpu_sysreg_r <= 1'b0;
         cpu_miss_r <= 1'b0;
         cpu_offset_r <= '0;
      end
      else
      begin
         cpu_sysreg_r <= i_cpu_req && cpu_sys_hit;
         cpu_miss_r <= i_cpu_req && !cpu_sys_hit;
         if (i_cpu_req)
            cpu_offset_r <= cpu_sys_hit ? cpu_rel[OFFSET_W-1:0] : '0;
      end
   end

   // All outputs come straight from flip-flops.
   assign o_host_sysreg_sel = host_sysreg_r;
   assign o_host_iram_sel = host_iram_r;
   assign o_host_reject = host_reject_r;
   assign o_host_offset = host_offset_r;
   assign o_iram_addr = iram_addr_r;
   assign o_cpu_sysreg_sel = cpu_sysreg_r;
   assign o_cpu_miss = cpu_miss_r;
   assign o_cpu_offset = cpu_offset_r;
   assign o_boot_mode = mode_r;
   assign o_mode_valid = mode_valid_r;
   assign o_host_if_en = host_en_r;
   assign o_debug_boot = debug_r;

endmodule // host_register_window_decode

// *** host_window_pkg.sv ***
package host_window_pkg;

   // Address widths of the two request sides and of the register offset.
   localparam int HOST_ADDR_W = 20;
   localparam int CPU_ADDR_W = 32;
   localparam int OFFSET_W = 16;

   // Base of the system register area as seen from the external host.
   localparam logic [HOST_ADDR_W-1:0] HOST_SYSREG_BASE = 20'hD_0000;
   // Base of the system register area as seen from the processor or DMA.
   localparam logic [CPU_ADDR_W-1:0] CPU_SYSREG_BASE = 32'h4001_0000;
   // Size of the system register area on either side.
   localparam logic [HOST_ADDR_W-1:0] SYSREG_SPAN = 20'h1_0000;

   // Instruction RAM mirror window in the host address space, 768 Kbytes.
   localparam logic [HOST_ADDR_W-1:0] MIRROR_BASE = 20'h0_0000;
   localparam logic [HOST_ADDR_W-1:0] MIRROR_SPAN = 20'hC_0000;
   // Base of the instruction RAM in the internal address space.
   localparam logic [CPU_ADDR_W-1:0] IRAM_BASE = 32'h0000_0000;

   // Boot modes, coded as {boot_select_high, boot_select_low}.
   localparam logic [1:0] BOOT_EXT_MEM = 2'h0;
   localparam logic [1:0] BOOT_SFLASH = 2'h1;
   localparam logic [1:0] BOOT_HOST = 2'h2;
   localparam logic [1:0] BOOT_IRAM = 2'h3;
   // Boot mode shown before the straps have been captured.
   localparam logic [1:0] BOOT_MODE_RST = 2'h0;

   // Last settle count; the straps may be captured five cycles after reset release.
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // Strap capture states.
   typedef enum logic [2:0]
   {
      ST_SETTLE = 3'h1,
      ST_CAPTURE = 3'h2,
      ST_RUN = 3'h4
   } strap_state_e;

endpackage

// *** pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 2
) (
   input wire logic i_clk,               // System clock.
   input wire logic i_rst_n,             // Synchronous reset, active low.
   input wire logic [WIDTH-1:0] i_pin,   // Asynchronous pin levels.
   output logic [WIDTH-1:0] o_level,     // Filtered level, from a flip-flop.
   output logic o_stable                 // All bits agree in stages two and three.
);

   logic [WIDTH-1:0] meta_r;    // First stage, read only by the second stage.
   logic [WIDTH-1:0] sync_r;    // Second stage.
   logic [WIDTH-1:0] hold_r;    // Third stage.
   logic [WIDTH-1:0] level_r;   // Accepted level.
   logic stable_r;              // Agreement flag.
   logic [WIDTH-1:0] agree;     // Per bit agreement of stages two and three.

   // Each bit accepts a new level only once two stages agree on it.
   genvar g;
   generate
      for (g = 0; g < WIDTH; g = g + 1)
      begin : g_bit
         assign agree[g] = (sync_r[g] == hold_r[g]);
         // The accepted level follows the pin once the later stages agree.
         always_ff @(posedge i_clk)
         begin
            if (!i_rst_n)
               level_r[g] <= 1'b0;
            else if (agree[g])
               level_r[g] <= hold_r[g];
         end
      end
   endgenerate

   // Three stage shift chain for the pin levels.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         meta_r <= '0;
         sync_r <= '0;
         hold_r <= '0;
         stable_r <= 1'b0;
      end
      else
      begin
         meta_r <= i_pin;
         sync_r <= meta_r;
         hold_r <= sync_r;
         stable_r <= &agree;
      end
   end

   assign o_level = level_r;
   assign o_stable = stable_r;

endmodule // pin_sync

// *** host_window_asserts.sv ***
`timescale 1ns/1ps
// Watches the decode block at its ports only.
module host_window_asserts
(
   input wire logic i_clk, // Clock.
   input wire logic i_rst_n, // Reset, low.
   input wire logic i_host_req, // Host strobe.
   input wire logic [host_window_pkg::HOST_ADDR_W-1:0] i_host_addr, // Host address.
   input wire logic i_cpu_req, // Internal strobe.
   input wire logic [host_window_pkg::CPU_ADDR_W-1:0] i_cpu_addr, // Internal address.
   input wire logic o_host_sysreg_sel, // Register hit.
   input wire logic o_host_iram_sel, // Mirror hit.
   input wire logic o_host_reject, // Refusal.
   input wire logic [host_window_pkg::OFFSET_W-1:0] o_host_offset, // Host offset.
   input wire logic [host_window_pkg::CPU_ADDR_W-1:0] o_iram_addr, // Mirror target.
   input wire logic o_cpu_sysreg_sel, // Internal hit.
   input wire logic o_cpu_miss, // Internal miss.
   input wire logic [host_window_pkg::OFFSET_W-1:0] o_cpu_offset, // Internal offset.
   input wire logic [1:0] o_boot_mode, // Captured mode.
   input wire logic o_mode_valid, // Mode captured.
   input wire logic o_host_if_en, // Host side on.
   input wire logic o_debug_boot // Debug mode.
);
   import host_window_pkg::*;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // Decoded views of the request addresses, worked out independently.
   wire logic hreg = (i_host_addr - HOST_SYSREG_BASE) < SYSREG_SPAN;
   wire logic hmir = (i_host_addr - MIRROR_BASE) < MIRROR_SPAN;
   wire logic chit = i_cpu_addr[31:16] == CPU_SYSREG_BASE[31:16];
   wire logic [15:0] hoff = 16'(i_host_addr - HOST_SYSREG_BASE);
   wire logic [15:0] coff = 16'(i_cpu_addr - CPU_SYSREG_BASE);
   wire logic [31:0] mtgt = IRAM_BASE + 32'(i_host_addr - MIRROR_BASE);
   // A host strobe taken while the given boot mode is in force.
   sequence s_req_in(logic [1:0] m);
      i_host_req && o_mode_valid && o_boot_mode == m;
   endsequence
   a_one_answer: assert property (
      i_host_req |=> $onehot({o_host_sysreg_sel, o_host_iram_sel, o_host_reject}))
      else $error("Host strobe without exactly one answer.");
   a_sysreg_hit: assert property (
      i_host_req && hreg && o_mode_valid && o_host_if_en |=>
      o_host_sysreg_sel && o_host_offset == $past(hoff)) else $error("Host register hit lost.");
   a_ext_off: assert property (
      s_req_in(2'h0) |=> o_host_reject) else $error("Host served while disabled.");
   a_flash_mirror: assert property (
      s_req_in(2'h1) ##0 hmir |=> o_host_reject && o_iram_addr == '0)
      else $error("Reserved mirror access served.");
   a_mirror_iram: assert property (
      i_host_req && hmir && o_mode_valid && o_boot_mode[1] |=>
      o_host_iram_sel && o_iram_addr == $past(mtgt)) else $error("Mirror access misrouted.");
   a_mode_flags: assert property (
      o_mode_valid |-> o_host_if_en == (o_boot_mode != 2'h0) &&
      o_debug_boot == (o_boot_mode == 2'h3)) else $error("Mode flags disagree with mode.");
   a_mode_hold: assert property (
      o_mode_valid |=> o_mode_valid && $stable(o_boot_mode)) else $error("Captured mode moved.");
   a_cpu_hit: assert property (
      i_cpu_req && chit |=> o_cpu_sysreg_sel && o_cpu_offset == $past(coff))
      else $error("Internal register hit lost.");
   a_cpu_miss: assert property (
      i_cpu_req && !chit |=> o_cpu_miss && !o_cpu_sysreg_sel) else $error("Internal miss lost.");
endmodule // host_window_asserts

// *** host_mcu_model.sv ***
`timescale 1ns/1ps
// External host: one strobe per access, address held with it.
module host_mcu_model
(
   input wire logic i_clk, // System clock.
   output logic o_req, // Access strobe.
   output logic [host_window_pkg::HOST_ADDR_W-1:0] o_addr // Access address.
);
   import host_window_pkg::*;
   initial
   begin
      o_req = 1'b0;
      o_addr = '0;
   end
   // Addresses given already carry the host side base; a released bus shows the inverse.
   task automatic access(input logic [HOST_ADDR_W-1:0] a);
      @(posedge i_clk);
      #1;
      o_req = 1'b1;
      o_addr = a;
      @(posedge i_clk);
      #1;
      o_req = 1'b0;
      o_addr = ~a;
   endtask
endmodule // host_mcu_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
   import host_window_pkg::*;
   logic clk, rst_n, bs_hi, bs_lo, cpu_req, hsel, hiram, hrej, csel, cmiss, mvalid, if_en, dbg;
   logic [31:0] cpu_addr, iaddr;
   logic [15:0] hoff, coff;
   logic [1:0] mode;
   wire logic host_req;
   wire logic [19:0] host_addr;
   int err_total, total_checks, cyc;
   host_mcu_model host (.i_clk(clk), .o_req(host_req), .o_addr(host_addr));
   host_register_window_decode uut (.i_clk(clk), .i_rst_n(rst_n), .i_boot_select_high(bs_hi),
      .i_boot_select_low(bs_lo), .i_host_req(host_req), .i_host_addr(host_addr),
      .i_cpu_req(cpu_req), .i_cpu_addr(cpu_addr), .o_host_sysreg_sel(hsel),
      .o_host_iram_sel(hiram), .o_host_reject(hrej), .o_host_offset(hoff), .o_iram_addr(iaddr),
      .o_cpu_sysreg_sel(csel), .o_cpu_miss(cmiss), .o_cpu_offset(coff), .o_boot_mode(mode),
      .o_mode_valid(mvalid), .o_host_if_en(if_en), .o_debug_boot(dbg));
   // Free running clock.
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Cuts a hang short.
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         err_total++;
         give_verdict();
      end
   end
   // Counts and reports one comparison.
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic give_verdict();
      if (err_total == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Resets with straps m, then probes register, mirror edge and a hole.
   task automatic run_mode(input logic [1:0] m);
      int n;
      logic [33:0] mir_exp;
      mir_exp = m[1] ? {2'h2, IRAM_BASE + 32'h000BFFFF} : {2'h1, 32'h0};
      rst_n = 1'b0;
      {bs_hi, bs_lo} = m;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      host.access(20'hD0010);
      chk({hsel, hiram, hrej}, 40'h1);
      n = 0;
      while (mvalid !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      {bs_hi, bs_lo} = ~m;
      host.access(20'hD0010);
      chk({hsel, hiram, hrej, hoff}, (m == 2'h0) ? {3'h1, 16'h0} : {3'h4, 16'h0010});
      host.access(20'hBFFFF);
      chk({hiram, hrej, iaddr}, mir_exp);
      host.access(20'hC0000);
      chk({hsel, hiram, hrej}, 40'h1);
      chk({mvalid, dbg, if_en, mode}, {1'b1, m == 2'h3, m != 2'h0, m});
   endtask
   // One internal strobe per cycle; the caller drops the strobe afterwards.
   task automatic cpu_one(input logic [31:0] a, input logic [39:0] e);
      cpu_req = 1'b1;
      cpu_addr = a;
      @(posedge clk);
      #1;
      chk({csel, cmiss, coff}, e);
   endtask
   // Back to back internal strobes across both edges of the register area.
   task automatic cpu_scn();
      cpu_one(32'h40010024, {2'h2, 16'h0024});
      cpu_one(32'h4001FFFF, {2'h2, 16'hFFFF});
      cpu_one(32'h40020000, {2'h1, 16'h0});
      cpu_one(32'h4000FFFF, {2'h1, 16'h0});
      cpu_req = 1'b0;
   endtask
   // Main sequence: every boot mode, then internal traffic.
   initial
   begin
      cpu_req = 1'b0;
      cpu_addr = 32'h0;
      for (int m = 0; m < 4; m++)
         run_mode(2'(m));
      cpu_scn();
      give_verdict();
   end
endmodule // tb
bind host_register_window_decode host_window_asserts chk (.i_clk, .i_rst_n, .i_host_req,
   .i_host_addr, .i_cpu_req, .i_cpu_addr, .o_host_sysreg_sel, .o_host_iram_sel, .o_host_reject,
   .o_host_offset, .o_iram_addr, .o_cpu_sysreg_sel, .o_cpu_miss, .o_cpu_offset, .o_boot_mode,
   .o_mode_valid, .o_host_if_en, .o_debug_boot);
